// ---- pkg/alu_map.svh ----
`ifndef ALU_MAP_SVH
`define ALU_MAP_SVH

// status flag positions
`define SREG_C 0
`define SREG_Z 1
`define SREG_N 2
`define SREG_V 3
`define SREG_S 4
`define SREG_H 5
`define SREG_T 6
`define SREG_I 7

// register offsets (byte addresses)
`define REG_CTRL 8'h00
`define REG_FLAGS 8'h04
`define REG_PC 8'h08
`define REG_COUNT 8'h0C

// field positions and reset values
`define CTRL_GO_BIT 0
`define CTRL_RESET 1'h1
`define SREG_RESET 8'h00
`define PC_RESET 16'h0000
`define COUNT_RESET 16'h0000

// clock counts per operation class
`define CLK_BYTE_OP 3'h1
`define CLK_WORD_OP 3'h2
`define CLK_JUMP 3'h2
`define CLK_CALL 3'h3
`define CLK_RETURN 3'h4
`define CLK_SKIP_NONE 3'h1
`define CLK_SKIP_ONE 3'h2
`define CLK_SKIP_TWO 3'h3

// constants
`define ALL_ONES 8'hFF
`define PC_STEP 16'h0001
`define SKIP_ONE_WORD 16'h0002
`define SKIP_TWO_WORD 16'h0003

`endif

// ---- pkg/alu_types_pkg.sv ----
package alu_types_pkg;

	typedef enum logic [4:0] {
		op_nop = 5'h00,
		op_add = 5'h01,
		op_add_carry = 5'h02,
		op_sub_regs = 5'h03,
		op_sub_regs_borrow = 5'h04,
		op_sub_const = 5'h05,
		op_sub_const_borrow = 5'h06,
		op_and_regs = 5'h07,
		op_and_const = 5'h08,
		op_or_regs = 5'h09,
		op_or_const = 5'h0A,
		op_xor_regs = 5'h0B,
		op_set_mask_bits = 5'h0C,
		op_clear_mask_bits = 5'h0D,
		op_test_register = 5'h0E,
		op_compare_regs = 5'h0F,
		op_compare_with_borrow = 5'h10,
		op_compare_immediate = 5'h11,
		op_word_add_imm = 5'h12,
		op_word_sub_imm = 5'h13,
		op_pointer_jump = 5'h14,
		op_pointer_call = 5'h15,
		op_offset_jump = 5'h16,
		op_offset_call = 5'h17,
		op_sub_return = 5'h18,
		op_irq_return = 5'h19,
		op_compare_skip_equal = 5'h1A,
		op_skip_bit_clear = 5'h1B
	} op_e;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_wait_two = 2'b01,
		st_wait_one = 2'b11,
		st_commit = 2'b10
	} seq_e;

	// one decoded operation with its operands
	typedef struct packed {
		op_e code;
		logic [7:0] dst;
		logic [7:0] src;
		logic [7:0] konst;
		logic [2:0] bit_sel;
		logic [15:0] pair;
		logic [5:0] word_k;
		logic [11:0] offset;
		logic [15:0] zptr;
		logic [15:0] stack_top;
		logic next_two_word;
	} op_s;

	// register file write-back
	typedef struct packed {
		logic lo_wr;
		logic hi_wr;
		logic [7:0] lo;
		logic [7:0] hi;
	} res_s;

endpackage

// ---- src/alu_branch_unit.sv ----
// Behaviour
// - add and add-with-carry write sum, set Z C N V H, one clock
// - word add-immediate adds constant to pair, sets Z C N V S, two clocks
// - word subtract-immediate writes both registers, sets Z C N V S, two clocks
// - register subtract, with optional borrow, writes difference, Z C N V H, one clock
// - constant subtract, with optional borrow, writes register, Z C N V H, one clock
// - and with register or constant writes result, only Z N V, one clock
// - or with register or constant, xor registers, Z N V, one clock
// - set-bits ors a mask into the register, Z N V, one clock
// - clear-bits ands with 0xFF minus mask, Z N V, one clock
// - test ands register with itself, value kept, Z N V, one clock
// - pointer jump loads program counter from Z, no flags, two clocks
// - pointer call pushes return address, loads Z, no flags, three clocks
// - compare-skip-equal skips next instruction when equal, no flags, 1/2/3 clocks
// - compare immediate sets Z N V C H without storing, one clock
// - skip-bit-clear skips next instruction when bit is zero, 1/2/3 clocks
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/10ps
`include "alu_map.svh"

module alu_branch_unit import alu_types_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic op_valid,
	input wire op_s op,
	output logic op_ready,
	output res_s wb,
	output logic [15:0] pc,
	output logic [7:0] sreg,
	output logic push_req,
	output logic [15:0] push_data,
	output logic pop_req
);

	// ************************************************************
	// operation decode
	// ************************************************************

	seq_e state;
	seq_e next_state;
	logic take;
	logic commit_now;
	logic ctrl_go;
	logic [15:0] op_count;
	logic [7:0] alu_b;
	logic [7:0] alu_res;
	logic [7:0] alu_flags;
	logic alu_writes;
	logic [16:0] word_sum;
	logic [16:0] word_dif;
	logic [15:0] word_res;
	logic skip;
	logic [15:0] offset_ext;
	logic [2:0] next_cycles;
	logic [15:0] next_pc;
	logic [7:0] next_sreg;
	res_s next_wb;
	logic next_push;
	logic next_pop;
	logic [15:0] stash_pc;
	logic [7:0] stash_sreg;
	res_s stash_wb;
	logic stash_push;
	logic stash_pop;
	logic bus_write;

	assign take = op_valid & op_ready;

	// constant forms take the immediate as second operand
	always_comb begin
		if (op.code inside {op_sub_const, op_sub_const_borrow, op_and_const, op_or_const,
			op_set_mask_bits, op_clear_mask_bits, op_compare_immediate}) begin
			alu_b = op.konst;
		end else begin
			alu_b = op.src;
		end
	end

	byte_alu u_byte_alu (
		.code(op.code),
		.a(op.dst),
		.b(alu_b),
		.flags_in(sreg),
		.res(alu_res),
		.flags_out(alu_flags),
		.writes(alu_writes)
	);

	assign word_sum = {1'b0, op.pair} + {11'h000, op.word_k};
	assign word_dif = {1'b0, op.pair} - {11'h000, op.word_k};
	assign offset_ext = {{4{op.offset[11]}}, op.offset};

	// ************************************************************
	// next program counter, flags and write-back
	// ************************************************************

	always_comb begin
		next_cycles = `CLK_BYTE_OP;
		next_pc = pc + `PC_STEP;
		next_sreg = sreg;
		next_wb = '0;
		next_push = 1'b0;
		next_pop = 1'b0;
		skip = 1'b0;
		word_res = word_sum[15:0];
		unique case (op.code)
			op_word_add_imm, op_word_sub_imm: begin
				next_cycles = `CLK_WORD_OP;
				next_wb.lo_wr = 1'b1;
				next_wb.hi_wr = 1'b1;
				if (op.code == op_word_add_imm) begin
					word_res = word_sum[15:0];
					next_sreg[`SREG_C] = word_sum[16];
					next_sreg[`SREG_V] = ~op.pair[15] & word_res[15];
				end else begin
					word_res = word_dif[15:0];
					next_sreg[`SREG_C] = word_dif[16];
					next_sreg[`SREG_V] = op.pair[15] & ~word_res[15];
				end
				next_wb.lo = word_res[7:0];
				next_wb.hi = word_res[15:8];
				next_sreg[`SREG_Z] = (word_res == 16'h0000);
				next_sreg[`SREG_N] = word_res[15];
				next_sreg[`SREG_S] = word_res[15] ^ next_sreg[`SREG_V];
			end
			op_pointer_jump: begin
				next_cycles = `CLK_JUMP;
				next_pc = op.zptr;
			end
			op_pointer_call: begin
				next_cycles = `CLK_CALL;
				next_pc = op.zptr;
				next_push = 1'b1;
			end
			op_offset_jump: begin
				next_cycles = `CLK_JUMP;
				next_pc = pc + offset_ext + `PC_STEP;
			end
			op_offset_call: begin
				next_cycles = `CLK_CALL;
				next_pc = pc + offset_ext + `PC_STEP;
				next_push = 1'b1;
			end
			op_sub_return, op_irq_return: begin
				next_cycles = `CLK_RETURN;
				next_pc = op.stack_top;
				next_pop = 1'b1;
				if (op.code == op_irq_return) begin
					next_sreg[`SREG_I] = 1'b1;
				end
			end
			op_compare_skip_equal, op_skip_bit_clear: begin
				if (op.code == op_compare_skip_equal) begin
					skip = (op.dst == op.src);
				end else begin
					skip = ~op.src[op.bit_sel];
				end
				if (!skip) begin
					next_cycles = `CLK_SKIP_NONE;
				end else if (op.next_two_word) begin
					next_cycles = `CLK_SKIP_TWO;
					next_pc = pc + `SKIP_TWO_WORD;
				end else begin
					next_cycles = `CLK_SKIP_ONE;
					next_pc = pc + `SKIP_ONE_WORD;
				end
			end
			op_nop: begin
				next_cycles = `CLK_BYTE_OP;
			end
			default: begin
				next_cycles = `CLK_BYTE_OP;
				next_sreg = alu_flags;
				next_wb.lo_wr = alu_writes;
				next_wb.lo = alu_res;
			end
		endcase
	end

	// ************************************************************
	// cycle sequencer
	// ************************************************************

	always_comb begin
		next_state = state;
		unique case (state)
			st_idle: begin
				if (take) begin
					unique case (next_cycles)
						`CLK_RETURN: next_state = st_wait_two;
						`CLK_CALL: next_state = st_wait_one;
						`CLK_WORD_OP: next_state = st_commit;
						default: next_state = st_idle;
					endcase
				end
			end
			st_wait_two: next_state = st_wait_one;
			st_wait_one: next_state = st_commit;
			st_commit: next_state = st_idle;
		endcase
	end

	assign commit_now = (take && next_cycles == `CLK_BYTE_OP) || state == st_commit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= st_idle;
			op_ready <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			// new work only once the previous operation has committed
			op_ready <= (next_state == st_idle) & ctrl_go;
		end
	end

	// multi-cycle operations hold their outcome until the last clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stash_pc <= `PC_RESET;
			stash_sreg <= `SREG_RESET;
			stash_wb <= '0;
			stash_push <= 1'b0;
			stash_pop <= 1'b0;
		end else if (clk_en && take) begin
			stash_pc <= next_pc;
			stash_sreg <= next_sreg;
			stash_wb <= next_wb;
			stash_push <= next_push;
			stash_pop <= next_pop;
		end
	end

	// ************************************************************
	// architectural state and write-back
	// ************************************************************

	assign bus_write = psel & penable & pready & pwrite;

	// a commit in the same cycle as a bus write wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc <= `PC_RESET;
			sreg <= `SREG_RESET;
		end else if (clk_en) begin
			if (commit_now) begin
				pc <= take ? next_pc : stash_pc;
				sreg <= take ? next_sreg : stash_sreg;
			end else if (bus_write && paddr == `REG_PC) begin
				pc <= pwdata[15:0];
			end else if (bus_write && paddr == `REG_FLAGS) begin
				sreg <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wb <= '0;
			push_req <= 1'b0;
			pop_req <= 1'b0;
			push_data <= `PC_RESET;
		end else if (clk_en) begin
			wb <= '0;
			push_req <= 1'b0;
			pop_req <= 1'b0;
			if (commit_now) begin
				wb <= take ? next_wb : stash_wb;
				push_req <= take ? next_push : stash_push;
				pop_req <= take ? next_pop : stash_pop;
				push_data <= pc + `PC_STEP;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_count <= `COUNT_RESET;
		end else if (clk_en && commit_now) begin
			op_count <= op_count + 16'h0001;
		end
	end

	// ************************************************************
	// apb slave
	// ************************************************************

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_go <= `CTRL_RESET;
		end else if (clk_en && bus_write && paddr == `REG_CTRL) begin
			ctrl_go <= pwdata[`CTRL_GO_BIT];
		end
	end

	// zero wait states: answer is registered in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (clk_en) begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel && !penable) begin
				unique case (paddr)
					`REG_CTRL: prdata <= {31'h0000_0000, ctrl_go};
					`REG_FLAGS: prdata <= {24'h00_0000, sreg};
					`REG_PC: prdata <= {16'h0000, pc};
					`REG_COUNT: prdata <= {16'h0000, op_count};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

endmodule

// ---- src/byte_alu.sv ----
`timescale 1ns/10ps
`include "alu_map.svh"

module byte_alu import alu_types_pkg::*; (
	input wire op_e code,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic [7:0] flags_in,
	output logic [7:0] res,
	output logic [7:0] flags_out,
	output logic writes
);

	logic cin;
	logic [8:0] sum9;
	logic [8:0] dif9;

	always_comb begin
		cin = flags_in[`SREG_C] & (code inside {op_add_carry, op_sub_regs_borrow,
			op_sub_const_borrow, op_compare_with_borrow});
		sum9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		dif9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
		res = a;
		flags_out = flags_in;
		writes = 1'b0;
		unique case (code)
			op_add, op_add_carry: begin
				res = sum9[7:0];
				writes = 1'b1;
				flags_out[`SREG_C] = sum9[8];
				flags_out[`SREG_H] = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
				flags_out[`SREG_V] = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
			end
			op_sub_regs, op_sub_regs_borrow, op_sub_const, op_sub_const_borrow,
			op_compare_regs, op_compare_with_borrow, op_compare_immediate: begin
				res = dif9[7:0];
				writes = !(code inside {op_compare_regs, op_compare_with_borrow,
					op_compare_immediate});
				flags_out[`SREG_C] = dif9[8];
				flags_out[`SREG_H] = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
				flags_out[`SREG_V] = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
			end
			op_and_regs, op_and_const: begin
				res = a & b;
				writes = 1'b1;
				flags_out[`SREG_V] = 1'b0;
			end
			op_or_regs, op_or_const, op_set_mask_bits: begin
				res = a | b;
				writes = 1'b1;
				flags_out[`SREG_V] = 1'b0;
			end
			op_xor_regs: begin
				res = a ^ b;
				writes = 1'b1;
				flags_out[`SREG_V] = 1'b0;
			end
			op_clear_mask_bits: begin
				res = a & (`ALL_ONES - b);
				writes = 1'b1;
				flags_out[`SREG_V] = 1'b0;
			end
			op_test_register: begin
				res = a & a;
				flags_out[`SREG_V] = 1'b0;
			end
			default: begin
				res = a;
			end
		endcase
		if (code inside {[op_add:op_compare_immediate]}) begin
			flags_out[`SREG_Z] = (res == 8'h00);
			flags_out[`SREG_N] = res[7];
		end
	end

endmodule

// ---- verification/alu_props.sv ----
`timescale 1ns/10ps
`include "alu_map.svh"

module alu_props import alu_types_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic op_valid,
	input wire op_s op,
	input wire logic op_ready,
	input wire res_s wb,
	input wire logic [15:0] pc,
	input wire logic [7:0] sreg,
	input wire logic push_req,
	input wire logic [15:0] push_data
);
	// ****************
	// operation and bus checks
	// ****************
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic tk;
	assign tk = op_valid && op_ready && clk_en;

	add_sum_a: assert property (
		tk && op.code == op_add |=> wb.lo_wr && wb.lo == $past(op.dst) + $past(op.src))
		else $error("add result wrong");
	sub_const_a: assert property (
		tk && op.code == op_sub_const |=> wb.lo_wr && wb.lo == $past(op.dst) - $past(op.konst))
		else $error("constant subtract wrong");
	clear_mask_a: assert property (
		tk && op.code == op_clear_mask_bits |=> wb.lo == ($past(op.dst) & ~$past(op.konst)))
		else $error("clear mask wrong");
	test_keep_a: assert property (
		tk && op.code == op_test_register |=> !wb.lo_wr && sreg[`SREG_Z] == ($past(op.dst) == 8'h00))
		else $error("test register wrong");
	cmp_carry_a: assert property (
		tk && op.code == op_compare_immediate
		|=> !wb.lo_wr && sreg[`SREG_C] == ($past(op.dst) < $past(op.konst)))
		else $error("compare immediate wrong");
	word_add_a: assert property (
		tk && op.code == op_word_add_imm |=> !op_ready ##1 wb.hi_wr
		&& {wb.hi, wb.lo} == 16'($past(op.pair, 2) + $past(op.word_k, 2)))
		else $error("word add wrong");
	ptr_jump_a: assert property (
		tk && op.code == op_pointer_jump |=> !op_ready ##1 pc == $past(op.zptr, 2) && $stable(sreg))
		else $error("pointer jump wrong");
	ptr_call_a: assert property (
		tk && op.code == op_pointer_call |=> !op_ready [*2] ##1 push_req
		&& pc == $past(op.zptr, 3) && push_data == $past(pc, 3) + 16'h0001)
		else $error("pointer call wrong");
	skip_equal_a: assert property (
		tk && op.code == op_compare_skip_equal && op.dst == op.src && !op.next_two_word
		|-> ##2 pc == $past(pc, 2) + 16'h0002)
		else $error("skip on equal wrong");
	apb_ready_a: assert property (psel && !penable && clk_en |=> pready)
		else $error("bus answer late");
endmodule

bind alu_branch_unit alu_props i_props (.pclk, .presetn, .clk_en, .psel, .penable, .pready,
	.op_valid, .op, .op_ready, .wb, .pc, .sreg, .push_req, .push_data);

// ---- verification/dec_model.sv ----
`timescale 1ns/10ps

module dec_model import alu_types_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic issue,
	input wire op_s next_op,
	input wire logic op_ready,
	output logic op_valid,
	output op_s op
);
	// *********************
	// decoder and registers
	// *********************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_valid <= 1'b0;
			op <= '0;
		end else if (op_valid && op_ready) begin
			op_valid <= 1'b0;
			// stale operands flip so a late sample shows up
			op <= op_s'(~op);
		end else if (issue) begin
			op_valid <= 1'b1;
			op <= next_op;
		end
	end
endmodule

// ---- verification/eight_bit_alu_branch_unit_tb.sv ----
`timescale 1ns/10ps
`include "alu_map.svh"
`define CHK(n, e, g) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("[FAIL] %s exp %0h got %0h", n, e, g); \
	end \
end

module eight_bit_alu_branch_unit_tb import alu_types_pkg::*; ();
	// *****
	// bench
	// *****
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic op_valid, op_ready, push_req, issue, cf, wr, clk_en;
	logic [7:0] paddr, sreg;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] pc, push_data, ep;
	logic [9:0] e;
	op_s o, nx, o_bus;
	res_s wb;
	int failures, comparisons, seed, st;
	op_e codes [15] = '{op_add, op_add_carry, op_sub_regs, op_sub_regs_borrow, op_sub_const,
		op_sub_const_borrow, op_and_regs, op_and_const, op_or_regs, op_or_const, op_xor_regs,
		op_set_mask_bits, op_clear_mask_bits, op_test_register, op_compare_immediate};

	alu_branch_unit i_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .op_valid, .op(o_bus), .op_ready, .wb, .pc, .sreg,
		.push_req, .push_data, .pop_req());
	dec_model i_dec (.pclk, .presetn, .issue, .next_op(nx), .op_ready, .op_valid, .op(o_bus));

	function automatic logic [9:0] expb(op_e c, logic [7:0] a, b, k, logic ci);
		logic [8:0] r;
		case (c)
			op_add: r = a + b;
			op_add_carry: r = a + b + ci;
			op_sub_regs: r = a - b;
			op_sub_regs_borrow: r = a - b - ci;
			op_sub_const, op_compare_immediate: r = a - k;
			op_sub_const_borrow: r = a - k - ci;
			op_and_regs: r = {ci, a & b};
			op_and_const: r = {ci, a & k};
			op_or_regs: r = {ci, a | b};
			op_or_const, op_set_mask_bits: r = {ci, a | k};
			op_xor_regs: r = {ci, a ^ b};
			op_clear_mask_bits: r = {ci, a & (8'hFF - k)};
			default: r = {ci, a};
		endcase
		return {r[8], r[7:0] == 8'h00, r[7:0]};
	endfunction

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// returns just after the commit edge of an n+1 clock operation
	task automatic run(input op_s p, input int n);
		@(posedge pclk);
		issue <= 1'b1;
		nx <= p;
		@(posedge pclk);
		issue <= 1'b0;
		do @(posedge pclk); while (op_valid !== 1'b1 || op_ready !== 1'b1);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	task automatic end_sim();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		end_sim();
	end

	initial begin
		{presetn, psel, penable, pwrite, issue, paddr, pwdata} = '0;
		nx = '0;
		clk_en = 1'b1;
		seed = 89;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int j = 0; j < 5; j++) begin
			apb(1'b0, 8'(4 * j), 32'h0000_0000);
			`CHK("reg", (j == 0) ? 32'h0000_0001 : 32'h0000_0000, rd)
			`CHK("err", j == 4, er)
		end
		apb(1'b1, `REG_FLAGS, 32'h0000_0021);
		apb(1'b1, `REG_PC, 32'h0000_0100);
		apb(1'b0, `REG_FLAGS, 32'h0000_0000);
		`CHK("flags", 32'h0000_0021, rd)
		cf = 1'b1;
		ep = 16'h0100;
		$display("test registers done");
		for (int i = 0; i < 60; i++) begin
			o = '0;
			o.code = codes[$unsigned($random(seed)) % 15];
			o.dst = (i < 3) ? 8'h80 : 8'($random(seed));
			o.src = (i < 3) ? 8'h80 : 8'($random(seed));
			o.konst = 8'($random(seed));
			e = expb(o.code, o.dst, o.src, o.konst, cf);
			wr = !(o.code inside {op_test_register, op_compare_immediate});
			run(o, 0);
			ep++;
			`CHK("write", wr, wb.lo_wr)
			if (wr) `CHK("res", e[7:0], wb.lo)
			`CHK("zero", e[8], sreg[`SREG_Z])
			`CHK("neg", e[7], sreg[`SREG_N])
			`CHK("carry", e[9], sreg[`SREG_C])
			if (o.code inside {op_add, op_add_carry})
				`CHK("half", 1'(5'(o.dst[3:0] + o.src[3:0] + cf) >> 4), sreg[`SREG_H])
			`CHK("pc", ep, pc)
			cf = e[9];
		end
		$display("test byte ops done");
		o = '0;
		o.code = op_word_add_imm;
		o.pair = 16'hFFFF;
		o.word_k = 6'h01;
		run(o, 1);
		`CHK("wadd", 18'h3_0000, {wb.lo_wr, wb.hi_wr, wb.hi, wb.lo})
		`CHK("wadd zc", 2'h3, {sreg[`SREG_Z], sreg[`SREG_C]})
		o.code = op_word_sub_imm;
		o.pair = 16'h0000;
		o.word_k = 6'h3F;
		run(o, 1);
		`CHK("wsub", 18'h3_FFC1, {wb.lo_wr, wb.hi_wr, wb.hi, wb.lo})
		`CHK("wsub zc", 2'h1, {sreg[`SREG_Z], sreg[`SREG_C]})
		o = '0;
		o.code = op_pointer_jump;
		o.zptr = 16'h1234;
		run(o, 1);
		`CHK("jump", 17'h1_1234, {sreg[`SREG_C], pc})
		o.code = op_pointer_call;
		o.zptr = 16'h0200;
		run(o, 2);
		`CHK("call", 33'h1_1235_0200, {push_req, push_data, pc})
		ep = 16'h0200;
		for (int j = 0; j < 5; j++) begin
			o = '0;
			o.code = (j < 2 || j == 4) ? op_compare_skip_equal : op_skip_bit_clear;
			o.dst = 8'h04;
			o.src = (j == 1) ? 8'h05 : 8'h04;
			o.bit_sel = (j == 2) ? 3'h3 : 3'h2;
			o.next_two_word = (j == 0);
			st = (j == 0) ? 3 : ((j == 2 || j == 4) ? 2 : 1);
			run(o, st - 1);
			ep += 16'(st);
			`CHK("skip", ep, pc)
		end
		$display("test flow done");
		// frozen clock enable must hold every flop
		@(posedge pclk);
		clk_en <= 1'b0;
		repeat (4) @(posedge pclk);
		#1;
		`CHK("hold", ep, pc)
		`CHK("hold rdy", 1'b1, op_ready)
		@(posedge pclk);
		clk_en <= 1'b1;
		apb(1'b1, `REG_COUNT, 32'h0000_FFFF);
		apb(1'b0, `REG_COUNT, 32'h0000_0000);
		`CHK("count", 32'h0000_0045, rd)
		$display("test count done");
		end_sim();
	end
endmodule
